// ===== ipr_input_remap.sv
// APB register file and input routing of the remappable pin select unit
`timescale 1ns/1ps

// Function
// - Lock bit at one blocks every selection register write.
// - Lock bit at zero lets software write all selection registers.
// - Lock register write takes effect only after the unlock sequence.
// - Unimplemented bits read zero and ignore writes.
// - External interrupt one comes from pin chosen by its upper byte.
// - Interrupt three from upper byte, interrupt two from lower byte.
// - Basic timer external clock comes from upper byte field.
// - Capture units a to d: capture upper byte, timer clock lower byte.
// - Multi capture unit: capture upper byte, timer clock lower byte.
// - Compare fault b from upper byte, fault a from lower byte.
// - PWM inputs nine, eleven upper bytes; eight, ten lower bytes.
// - Encoder one phase b upper byte, phase a lower byte.
// - Encoder one home upper byte, index lower byte.
module ipr_input_remap (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ipr_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [ipr_pkg::PIN_CNT-1:0]     rp_pin_in,
    output logic                                 ext_irq_one_in,
    output logic                                 ext_irq_two_in,
    output logic                                 ext_irq_three_in,
    output logic                                 basic_timer_ext_clock,
    output logic      [3:0]                      capture_in,
    output logic      [3:0]                      capture_timer_clock,
    output logic                                 multi_capture_in,
    output logic                                 multi_capture_timer_clock,
    output logic                                 compare_fault_a,
    output logic                                 compare_fault_b,
    output logic                                 pwm_ctrl_input_eight,
    output logic                                 pwm_ctrl_input_nine,
    output logic                                 pwm_ctrl_input_ten,
    output logic                                 pwm_ctrl_input_eleven,
    output logic                                 encoder_one_phase_a,
    output logic                                 encoder_one_phase_b,
    output logic                                 encoder_one_home,
    output logic                                 encoder_one_index
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [ipr_pkg::SEL_CNT-1:0][15:0]  sel_ff;
    logic                               lock_ff;
    ipr_pkg::ipr_unlock_t               ul_ff;
    ipr_pkg::ipr_unlock_t               nxt_ul;
    logic [ipr_pkg::ROUTE_CNT-1:0]      route_ff;
    logic [31:0]                        prdata_ff;
    logic                               pready_ff;
    logic                               pslverr_ff;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [11:0]                        rel_addr;
    logic [3:0]                         sel_idx;
    logic                               aligned;
    logic                               is_lock;
    logic                               is_key;
    logic                               is_sel;
    logic                               hit;
    logic                               acc;
    logic                               wr;
    logic                               wr_sel;
    logic                               wr_lock;
    logic                               wr_key;
    logic [15:0]                        lane_mask;
    logic [15:0]                        nxt_sel;
    logic [31:0]                        rd_val;

    assign rel_addr  = paddr - ipr_pkg::SEL_OFS;
    assign sel_idx   = rel_addr[5:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign is_lock   = (paddr == ipr_pkg::LOCK_OFS);
    assign is_key    = (paddr == ipr_pkg::KEY_OFS);
    assign is_sel    = aligned && (paddr >= ipr_pkg::SEL_OFS) && (paddr < ipr_pkg::SEL_END);
    assign hit       = is_lock || is_key || is_sel;

    // A transfer completes at the edge where pready is seen high
    assign acc       = psel && penable && pready_ff;
    assign wr        = acc && pwrite;
    assign wr_sel    = wr && is_sel;
    assign wr_lock   = wr && is_lock;
    assign wr_key    = wr && is_key;
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Unwritten lanes keep their value, unimplemented bits stay zero
    assign nxt_sel = ((sel_ff[sel_idx] & ~lane_mask) | (pwdata[15:0] & lane_mask))
                     & ipr_pkg::sel_mask(sel_idx);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_lock) begin
            rd_val[ipr_pkg::LOCK_BIT] = lock_ff;
        end else if (is_key) begin
            rd_val[0] = (ul_ff == ipr_pkg::UL_ARMED);
        end else if (is_sel) begin
            rd_val[15:0] = sel_ff[sel_idx];
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // One setup and one access cycle per transfer, never a wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_ff <= !hit;
        end else if (acc) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    // Two key writes back to back arm a single lock write; any other
    // write in between except a repeated first key disarms, so stray code cannot flip the lock
    always_comb begin
        nxt_ul = ul_ff;
        if (wr) begin
            unique case (ul_ff)
                ipr_pkg::UL_IDLE: begin
                    nxt_ul = (wr_key && pwdata[15:0] == ipr_pkg::UNLOCK_KEY1)
                             ? ipr_pkg::UL_KEY1 : ipr_pkg::UL_IDLE;
                end
                ipr_pkg::UL_KEY1: begin
                    if (wr_key && pwdata[15:0] == ipr_pkg::UNLOCK_KEY2) begin
                        nxt_ul = ipr_pkg::UL_ARMED;
                    end else if (wr_key && pwdata[15:0] == ipr_pkg::UNLOCK_KEY1) begin
                        nxt_ul = ipr_pkg::UL_KEY1;
                    end else begin
                        nxt_ul = ipr_pkg::UL_IDLE;
                    end
                end
                ipr_pkg::UL_ARMED: begin
                    nxt_ul = ipr_pkg::UL_IDLE;
                end
                default: begin
                    nxt_ul = ipr_pkg::UL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ul_ff <= ipr_pkg::UL_IDLE;
        end else begin
            ul_ff <= nxt_ul;
        end
    end

    // ------------------------------------------------------------
    // Lock bit
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= 1'b0;
        end else if (wr_lock && pstrb[1] && ul_ff == ipr_pkg::UL_ARMED) begin
            lock_ff <= pwdata[ipr_pkg::LOCK_BIT];
        end
    end

    // ------------------------------------------------------------
    // Selection registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= '0;
        end else if (wr_sel && !lock_ff) begin
            sel_ff[sel_idx] <= nxt_sel;
        end
    end

    // ------------------------------------------------------------
    // Input routing
    // ------------------------------------------------------------
    // A field value is used directly as the pin number; the translation
    // to package pins is done by the pad ring outside this unit
    logic [16*ipr_pkg::SEL_CNT-1:0]     sel_flat;
    assign sel_flat = sel_ff;

    generate
        for (genvar r = 0; r < ipr_pkg::ROUTE_CNT; r++) begin : g_route
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    route_ff[r] <= 1'b0;
                end else begin
                    route_ff[r] <= rp_pin_in[sel_flat[ipr_pkg::ROUTE_POS[r] +: 8]];
                end
            end
        end
    endgenerate

    assign ext_irq_one_in            = route_ff[0];
    assign ext_irq_three_in          = route_ff[1];
    assign ext_irq_two_in            = route_ff[2];
    assign basic_timer_ext_clock     = route_ff[3];
    assign capture_in                = route_ff[7:4];
    assign capture_timer_clock       = route_ff[11:8];
    assign multi_capture_in          = route_ff[12];
    assign multi_capture_timer_clock = route_ff[13];
    assign compare_fault_b           = route_ff[14];
    assign compare_fault_a           = route_ff[15];
    assign pwm_ctrl_input_nine       = route_ff[16];
    assign pwm_ctrl_input_eight      = route_ff[17];
    assign pwm_ctrl_input_eleven     = route_ff[18];
    assign pwm_ctrl_input_ten        = route_ff[19];
    assign encoder_one_phase_b       = route_ff[20];
    assign encoder_one_phase_a       = route_ff[21];
    assign encoder_one_home          = route_ff[22];
    assign encoder_one_index         = route_ff[23];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [ipr_pkg::PIN_CNT-1:0]        pins_q;
    logic [ipr_pkg::SEL_CNT-1:0][15:0]  sel_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= '0;
            sel_q  <= '0;
        end else begin
            pins_q <= rp_pin_in;
            sel_q  <= sel_ff;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    lock_block_a: assert property (
        lock_ff |=> $stable(sel_ff)
    ) else $error("Selection register changed while locked");

    sel_write_a: assert property (
        wr_sel && !lock_ff && pstrb[1:0] == 2'b11 |=>
        sel_ff[$past(sel_idx)] == ($past(pwdata[15:0]) & ipr_pkg::sel_mask($past(sel_idx)))
    ) else $error("Unlocked selection write not stored");

    lock_seq_a: assert property (
        $changed(lock_ff) |-> $past(ul_ff) == ipr_pkg::UL_ARMED && $past(wr_lock)
    ) else $error("Lock bit changed without unlock sequence");

    lock_discard_a: assert property (
        wr_lock && ul_ff != ipr_pkg::UL_ARMED |=> $stable(lock_ff)
    ) else $error("Unarmed lock write took effect");

    unimpl_zero_a: assert property (
        pready_ff |-> prdata_ff[31:16] == 16'h0000 && sel_ff[0][7:0] == 8'h00
            && sel_ff[2][7:0] == 8'h00
    ) else $error("Unimplemented bits not zero");

    irq_one_route_a: assert property (
        ext_irq_one_in == pins_q[sel_q[ipr_pkg::IRQ_ONE_SEL][15:8]]
    ) else $error("Interrupt one misrouted");

    irq_two_three_a: assert property (
        ext_irq_three_in == pins_q[sel_q[ipr_pkg::IRQ_TWO3_SEL][15:8]]
        && ext_irq_two_in == pins_q[sel_q[ipr_pkg::IRQ_TWO3_SEL][7:0]]
    ) else $error("Interrupt two or three misrouted");

    timer_clk_route_a: assert property (
        basic_timer_ext_clock == pins_q[sel_q[ipr_pkg::TIMER_SEL][15:8]]
    ) else $error("Timer clock misrouted");

    capture_route_a: assert property (
        capture_in[3] == pins_q[sel_q[ipr_pkg::CAP_A_SEL+3][15:8]]
        && capture_in[0] == pins_q[sel_q[ipr_pkg::CAP_A_SEL][15:8]]
        && capture_timer_clock[0] == pins_q[sel_q[ipr_pkg::CAP_A_SEL][7:0]]
        && capture_timer_clock[3] == pins_q[sel_q[ipr_pkg::CAP_A_SEL+3][7:0]]
    ) else $error("Capture input misrouted");

    multi_cap_route_a: assert property (
        multi_capture_in == pins_q[sel_q[ipr_pkg::MULTI_SEL][15:8]]
        && multi_capture_timer_clock == pins_q[sel_q[ipr_pkg::MULTI_SEL][7:0]]
    ) else $error("Multi capture input misrouted");

    fault_route_a: assert property (
        compare_fault_b == pins_q[sel_q[ipr_pkg::FAULT_SEL][15:8]]
        && compare_fault_a == pins_q[sel_q[ipr_pkg::FAULT_SEL][7:0]]
    ) else $error("Compare fault misrouted");

    pwm_route_a: assert property (
        pwm_ctrl_input_nine == pins_q[sel_q[ipr_pkg::PWM_89_SEL][15:8]]
        && pwm_ctrl_input_eight == pins_q[sel_q[ipr_pkg::PWM_89_SEL][7:0]]
        && pwm_ctrl_input_eleven == pins_q[sel_q[ipr_pkg::PWM_1011_SEL][15:8]]
        && pwm_ctrl_input_ten == pins_q[sel_q[ipr_pkg::PWM_1011_SEL][7:0]]
    ) else $error("PWM input misrouted");

    enc_phase_route_a: assert property (
        encoder_one_phase_b == pins_q[sel_q[ipr_pkg::ENC_PH_SEL][15:8]]
        && encoder_one_phase_a == pins_q[sel_q[ipr_pkg::ENC_PH_SEL][7:0]]
    ) else $error("Encoder phase misrouted");

    enc_home_route_a: assert property (
        encoder_one_home == pins_q[sel_q[ipr_pkg::ENC_HOME_SEL][15:8]]
        && encoder_one_index == pins_q[sel_q[ipr_pkg::ENC_HOME_SEL][7:0]]
    ) else $error("Encoder home or index misrouted");

    apb_answer_a: assert property (
        psel && !penable |=> pready_ff ##1 !pready_ff
    ) else $error("APB answer not after one access cycle");

    armed_once_a: assert property (
        ul_ff == ipr_pkg::UL_ARMED && wr |=> ul_ff == ipr_pkg::UL_IDLE
    ) else $error("Unlock arming survived a write");

    slave_error_a: assert property (
        psel && !penable |=> pslverr_ff == !$past(hit)
    ) else $error("Slave error does not match address decode");

    answer_clear_a: assert property (
        acc |=> prdata_ff == 32'h0000_0000 && !pslverr_ff
    ) else $error("Read data or error held past the access cycle");

    lock_set_c: cover property (
        $rose(lock_ff)
    );

    blocked_write_c: cover property (
        wr_sel && lock_ff
    );

    unlock_arm_c: cover property (
        ul_ff == ipr_pkg::UL_KEY1 ##[1:8] ul_ff == ipr_pkg::UL_ARMED
    );

    unmapped_c: cover property (
        pslverr_ff && pready_ff
    );

    lock_clear_c: cover property (
        $fell(lock_ff)
    );

endmodule

// ===== ipr_input_remap_tb_top.sv
// Self-checking bench for the input pin remap unit
`timescale 1ns/1ps
module ipr_input_remap_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                            pclk    = 1'b0;
    logic                            presetn = 1'b0;
    logic                            psel    = 1'b0;
    logic                            penable = 1'b0;
    logic                            pwrite  = 1'b0;
    logic [ipr_pkg::ADDR_W-1:0]      paddr   = '0;
    logic [31:0]                     pwdata  = '0;
    logic [3:0]                      pstrb   = '0;
    logic [31:0]                     prdata;
    logic                            pready;
    logic                            pslverr;
    logic [ipr_pkg::PIN_CNT-1:0]     pins;
    logic [ipr_pkg::PIN_CNT-1:0]     pins_d;
    logic [23:0]                     routed;
    logic [15:0]                     sel_m [13];
    logic                            lock_m;
    logic [33:0]                     notes [$];
    int                              miscompares = 0;
    int                              checks_done = 0;
    // Route k: owning register and whether it sits in the upper byte
    localparam int          RT_REG [24] = '{0, 1, 1, 2, 3, 4, 5, 6, 3, 4, 5, 6,
                                            7, 7, 8, 8, 9, 9, 10, 10, 11, 11, 12, 12};
    localparam logic [23:0] RT_HI       = 24'h5550fb;

    always #10 pclk = ~pclk;

    ipr_pin_model pm (.pclk(pclk), .rp_pin(pins), .rp_pin_d(pins_d));

    ipr_input_remap dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rp_pin_in(pins), .ext_irq_one_in(routed[0]),
        .ext_irq_three_in(routed[1]), .ext_irq_two_in(routed[2]),
        .basic_timer_ext_clock(routed[3]), .capture_in(routed[7:4]),
        .capture_timer_clock(routed[11:8]), .multi_capture_in(routed[12]),
        .multi_capture_timer_clock(routed[13]), .compare_fault_b(routed[14]),
        .compare_fault_a(routed[15]), .pwm_ctrl_input_nine(routed[16]),
        .pwm_ctrl_input_eight(routed[17]), .pwm_ctrl_input_eleven(routed[18]),
        .pwm_ctrl_input_ten(routed[19]), .encoder_one_phase_b(routed[20]),
        .encoder_one_phase_a(routed[21]), .encoder_one_home(routed[22]),
        .encoder_one_index(routed[23]));

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Monitor: each completed transfer takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                cmp_bit("note_queue", 1'b1, 1'b0);
            end else begin
                logic [33:0] nt;
                nt = notes.pop_front();
                cmp_bit("pslverr", nt[32], pslverr);
                if (nt[33]) cmp("prdata", nt[31:0], prdata);
            end
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] exp_d, input logic exp_e);
        int n;
        @(posedge pclk);
        notes.push_back({~wr, exp_e, exp_d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            miscompares++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0, 4'h0, exp, e);
    endtask

    task automatic key(input logic [15:0] k);
        apb(1'b1, 12'h040, {16'h0, k}, 4'hf, 32'h0, 1'b0);
    endtask

    // Writes a selection register and updates the expected image
    task automatic wsel(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] bm;
        bm = {{8{s[1]}}, {8{s[0]}}} & ((i == 0 || i == 2) ? 16'hff00 : 16'hffff);
        if (!lock_m) sel_m[i] = (sel_m[i] & ~bm) | (d[15:0] & bm);
        apb(1'b1, 12'(4 + 4 * i), d, s, 32'h0, 1'b0);
    endtask

    task automatic rd_all();
        for (int i = 0; i < 13; i++) rd(12'(4 + 4 * i), {16'h0, sel_m[i]}, 1'b0);
    endtask

    // Output at a quiet moment equals the selected pin one edge earlier
    task automatic chk_route(input int cyc);
        logic [23:0] exp;
        logic [15:0] r;
        repeat (2) @(posedge pclk);
        for (int c = 0; c < cyc; c++) begin
            @(negedge pclk);
            for (int k = 0; k < 24; k++) begin
                r = sel_m[RT_REG[k]];
                exp[k] = pins_d[RT_HI[k] ? r[15:8] : r[7:0]];
            end
            cmp("routed", 32'(exp), 32'(routed));
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hfd61));
        lock_m = 1'b0;
        foreach (sel_m[i]) sel_m[i] = 16'h0;
        repeat (20) @(posedge pclk);
        cmp("reset_routed", 32'h0, 32'(routed));
        presetn <= 1'b1;
        chk_route(3);
        rd_all();
        rd(12'h000, 32'h0, 1'b0);
        rd(12'h038, 32'h0, 1'b1);
        rd(12'h002, 32'h0, 1'b1);
        apb(1'b1, 12'h03c, 32'h1234, 4'hf, 32'h0, 1'b1);
        for (int i = 0; i < 13; i++) wsel(i, $urandom, 4'hf);
        rd_all();
        chk_route(4);
        wsel(1, $urandom, 4'b0001);
        wsel(3, $urandom, 4'b0010);
        rd_all();
        apb(1'b1, 12'h000, 32'h0800, 4'hf, 32'h0, 1'b0);
        rd(12'h000, 32'h0, 1'b0);
        key(16'h55aa);
        key(16'h1234);
        apb(1'b1, 12'h000, 32'h0800, 4'hf, 32'h0, 1'b0);
        rd(12'h000, 32'h0, 1'b0);
        key(16'h55aa);
        key(16'haa55);
        rd(12'h040, 32'h0000_0001, 1'b0);
        apb(1'b1, 12'h000, 32'hffffffff, 4'hf, 32'h0, 1'b0);
        rd(12'h040, 32'h0000_0000, 1'b0);
        lock_m = 1'b1;
        rd(12'h000, 32'h0800, 1'b0);
        for (int i = 0; i < 13; i++) wsel(i, $urandom, 4'hf);
        rd_all();
        chk_route(3);
        key(16'h55aa);
        key(16'haa55);
        apb(1'b1, 12'h000, 32'h0, 4'hf, 32'h0, 1'b0);
        lock_m = 1'b0;
        rd(12'h000, 32'h0, 1'b0);
        for (int i = 0; i < 13; i++) wsel(i, $urandom, 4'hf);
        rd_all();
        chk_route(3);
        summarize();
    end
endmodule

// ===== ipr_pin_model.sv
// Pin-side model: remappable pin levels seen by the remap unit
`timescale 1ns/1ps
module ipr_pin_model (
    input  wire logic                        pclk,
    output logic [ipr_pkg::PIN_CNT-1:0]      rp_pin,
    output logic [ipr_pkg::PIN_CNT-1:0]      rp_pin_d
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    // Every pin gets a fresh random level each cycle, so a wrong pin index shows quickly
    initial begin
        rp_pin = '0;
        rp_pin_d = '0;
    end
    always @(posedge pclk) begin
        rp_pin_d <= rp_pin;
        for (int w = 0; w < ipr_pkg::PIN_CNT / 32; w++) begin
            rp_pin[32*w +: 32] <= $urandom;
        end
    end
endmodule

// ===== ipr_pkg.sv
// Constants, register map and field layout of the input pin remap unit
package ipr_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 12;
    localparam int          SEL_CNT     = 13;
    localparam int          PIN_CNT     = 256;
    localparam int          ROUTE_CNT   = 24;
    localparam logic [11:0] LOCK_OFS    = 12'h000;
    localparam logic [11:0] SEL_OFS     = 12'h004;
    localparam logic [11:0] SEL_END     = 12'h038;
    localparam logic [11:0] KEY_OFS     = 12'h040;

    // Selection register indices
    localparam int IRQ_ONE_SEL   = 0;
    localparam int IRQ_TWO3_SEL  = 1;
    localparam int TIMER_SEL     = 2;
    localparam int CAP_A_SEL     = 3;
    localparam int MULTI_SEL     = 7;
    localparam int FAULT_SEL     = 8;
    localparam int PWM_89_SEL    = 9;
    localparam int PWM_1011_SEL  = 10;
    localparam int ENC_PH_SEL    = 11;
    localparam int ENC_HOME_SEL  = 12;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          LOCK_BIT    = 11;
    localparam int          HI_POS      = 8;
    localparam int          LO_POS      = 0;
    localparam logic [15:0] REG_RST     = 16'h0000;
    localparam logic [15:0] MASK_FULL   = 16'hffff;
    localparam logic [15:0] MASK_HI     = 16'hff00;
    localparam logic [15:0] UNLOCK_KEY1 = 16'h55aa;
    localparam logic [15:0] UNLOCK_KEY2 = 16'haa55;

    // Bit position of each routed field inside the flat selection vector
    localparam int ROUTE_POS [ROUTE_CNT] = '{
        16*0 + 8,  16*1 + 8,  16*1 + 0,  16*2 + 8,
        16*3 + 8,  16*4 + 8,  16*5 + 8,  16*6 + 8,
        16*3 + 0,  16*4 + 0,  16*5 + 0,  16*6 + 0,
        16*7 + 8,  16*7 + 0,  16*8 + 8,  16*8 + 0,
        16*9 + 8,  16*9 + 0,  16*10 + 8, 16*10 + 0,
        16*11 + 8, 16*11 + 0, 16*12 + 8, 16*12 + 0
    };

    typedef enum logic [1:0] {
        UL_IDLE  = 2'b00,
        UL_KEY1  = 2'b01,
        UL_ARMED = 2'b10
    } ipr_unlock_t;

    function automatic logic [15:0] sel_mask(input logic [3:0] idx);
        sel_mask = (idx == 4'(IRQ_ONE_SEL) || idx == 4'(TIMER_SEL)) ? MASK_HI : MASK_FULL;
    endfunction

endpackage
